//--- logic/iwc_idle_wakeup_controller.sv
// Behaviour
// - command byte 07 is the idle request; once its last parameter byte is accepted it enters the wait state at the next slow tick.
// - mask bits 7:6 divide the slow clock by 1, 2, 4 or 8.
// - mask bits 4..0 enable select, interrupt, field, tag and timeout wake.
// - period byte spaces tag trials and scales the timeout.
// - timeout after 256 slow periods times (period+2) times (limit+1).
// - wait oscillator-delay byte slow periods for the fast oscillator.
// - wait converter-delay byte slow periods before comparing.
// - threshold bytes are lower and upper tag comparator limits.
// - swing byte limits carrier swings per tag burst.
// - limit byte bounds tag trials and scales inactivity before timeout.
// - on leaving, reply 00, 01, then prescaler and waking source flag.
// - a wrong length is answered with 82 then 00.
// - slow period is the reciprocal of the prescaled slow clock rate.
//
// The register offsets and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ps
module iwc_idle_wakeup_controller
#(
	parameter int SLOW_DIV = iwc_pkg::IWC_SLOW_DIV
)
(
	input  wire logic        clk,
	input  wire logic        sys_rst,
	input  wire logic [1:0]  avs_address,
	input  wire logic        avs_read,
	input  wire logic        avs_write,
	input  wire logic [31:0] avs_writedata,
	output logic      [31:0] avs_readdata,
	output logic             avs_waitrequest,
	input  wire logic        ss_n,
	input  wire logic        irq_in_n,
	input  wire logic        field_on,
	input  wire logic [7:0]  tag_level,
	output logic      [15:0] resource_word,
	output logic             low_power,
	output logic             tag_burst
);
	import iwc_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		iwc_state_e            st;
		logic                  wreq;
		logic [31:0]           rdata;
		logic [IWC_IDX_W-1:0]  rx_idx;
		logic [2:0][7:0]       resp;
		logic [1:0]            resp_cnt;
		logic [7:0]            wake_flags;
		logic [IWC_DIV_W-1:0]  div_cnt;
		logic [IWC_PER_W-1:0]  per_cnt;
		logic [8:0]            trial_cnt;
		logic [7:0]            dly_cnt;
		logic [7:0]            swing_cnt;
		logic [15:0]           res;
		logic                  lowp;
		logic                  burst;
		logic [2:0]            pin_s1;
		logic [2:0]            pin_s2;
		logic [7:0]            tag_s1;
		logic [7:0]            tag_s2;
	} iwc_ctrl_s;

	iwc_ctrl_s q, d;

	iwc_param_if pif ();

	iwc_param_store u_store
	(
		.clk     (clk),
		.sys_rst (sys_rst),
		.pif     (pif)
	);

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [IWC_DIV_W-1:0] slow_limit(input logic [1:0] presc);
		slow_limit = IWC_DIV_W'((SLOW_DIV << presc) - 1);
	endfunction

	function automatic logic [15:0] word_of(input logic [7:0] lo, input logic [7:0] hi);
		word_of = {hi, lo};
	endfunction

	function automatic logic outside(input logic [7:0] lvl, input logic [7:0] lo,
		input logic [7:0] hi);
		outside = (lvl < lo) || (lvl > hi);
	endfunction

	assign avs_readdata    = q.rdata;
	assign avs_waitrequest = q.wreq;
	assign resource_word   = q.res;
	assign low_power       = q.lowp;
	assign tag_burst       = q.burst;

	logic [7:0]           src;
	logic [1:0]           presc;
	logic                 tick;
	logic                 per_wrap;
	logic [IWC_PER_W-1:0] per_lim;
	logic [IWC_SRC_N-1:0] act;
	logic [IWC_SRC_N-1:0] hit;
	logic                 waiting;
	logic                 start;
	logic                 take;

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb
	begin
		d           = q;
		src         = pif.prm[IWC_P_SRC];
		presc       = src[IWC_SRC_PRESC_HI:IWC_SRC_PRESC_LO];
		pif.wr_en   = 1'b0;
		pif.wr_idx  = q.rx_idx - IWC_RX_FIRST;
		pif.wr_data = avs_writedata[7:0];

		d.pin_s1 = {ss_n, irq_in_n, field_on};
		d.pin_s2 = q.pin_s1;
		d.tag_s1 = tag_level;
		d.tag_s2 = q.tag_s1;

		start = (avs_read || avs_write) && q.wreq;
		take  = (avs_read || avs_write) && !q.wreq;

		// slow period from prescaled divider
		tick = (q.div_cnt == slow_limit(presc));
		per_lim = IWC_TREF_TICKS * ({9'h000, pif.prm[IWC_P_PERIOD]} + IWC_PERIOD_OFS)
			- 17'h00001;
		per_wrap = tick && (q.per_cnt == per_lim);
		waiting = (q.st == IWC_WAIT) || (q.st == IWC_OSC) || (q.st == IWC_DAC)
			|| (q.st == IWC_BURST) || (q.st == IWC_CMP);

		// wake sources
		act[IWC_SRC_SS]    = !q.pin_s2[2];
		act[IWC_SRC_IRQ]   = !q.pin_s2[1];
		act[IWC_SRC_FIELD] = q.pin_s2[0];
		act[IWC_SRC_TAG]   = (q.st == IWC_CMP) && outside(q.tag_s2,
			pif.prm[IWC_P_THR_LO], pif.prm[IWC_P_THR_HI]);
		act[IWC_SRC_TMO]   = per_wrap && (q.trial_cnt + IWC_SLEEP_OFS
			== {1'b0, pif.prm[IWC_P_SLEEP]} + IWC_SLEEP_OFS);
		hit = act & src[IWC_SRC_N-1:0];

		// ------------------------------------------------------------
		// register bus
		// ------------------------------------------------------------
		if (start)
		begin
			d.wreq = 1'b0;
			unique case (avs_address)
				IWC_REG_CMD:  d.rdata = '0;
				IWC_REG_RESP: d.rdata = {23'h000000, q.resp_cnt != 2'h0, q.resp[0]};
				IWC_REG_STAT: d.rdata = {22'h000000, q.resp_cnt, q.st};
				IWC_REG_WAKE: d.rdata = {24'h000000, q.wake_flags};
			endcase
		end
		if (take)
		begin
			d.wreq = 1'b1;
			if (avs_read && avs_address == IWC_REG_RESP && q.resp_cnt != 2'h0)
			begin
				d.resp     = {8'h00, q.resp[2], q.resp[1]};
				d.resp_cnt = q.resp_cnt - 2'h1;
			end
			if (avs_write && avs_address == IWC_REG_CMD && q.st == IWC_READY
				&& q.resp_cnt == 2'h0)
			begin
				unique case (q.rx_idx)
					IWC_RX_CODE:
					begin
						if (avs_writedata[7:0] == IWC_CMD_IDLE)
						begin
							d.rx_idx = IWC_RX_LEN;
						end
					end
					IWC_RX_LEN:
					begin
						if (avs_writedata[7:0] == IWC_LEN_IDLE)
						begin
							d.rx_idx = IWC_RX_FIRST;
						end
						else
						begin
							d.rx_idx   = IWC_RX_CODE;
							d.resp     = {8'h00, IWC_ERR_LEN_LEN, IWC_ERR_LEN};
							d.resp_cnt = 2'h2;
						end
					end
					default:
					begin
						pif.wr_en = 1'b1;
						if (q.rx_idx == IWC_RX_LAST)
						begin
							d.rx_idx = IWC_RX_CODE;
							d.st     = IWC_ENTER;
						end
						else
						begin
							d.rx_idx = q.rx_idx + 4'h1;
						end
					end
				endcase
			end
		end

		// ------------------------------------------------------------
		// slow timing
		// ------------------------------------------------------------
		if (q.st == IWC_READY || q.st == IWC_LEAVE || tick)
		begin
			d.div_cnt = '0;
		end
		else
		begin
			d.div_cnt = q.div_cnt + 1'b1;
		end
		if (waiting && tick)
		begin
			if (per_wrap)
			begin
				d.per_cnt   = '0;
				d.trial_cnt = q.trial_cnt + 9'h001;
			end
			else
			begin
				d.per_cnt = q.per_cnt + 1'b1;
			end
		end

		// ------------------------------------------------------------
		// sequencing
		// ------------------------------------------------------------
		unique case (q.st)
			IWC_READY: d.lowp = 1'b0;
			IWC_ENTER:
			begin
				d.lowp      = 1'b1;
				d.res       = word_of(pif.prm[IWC_P_ENT_LO], pif.prm[IWC_P_ENT_HI]);
				d.per_cnt   = '0;
				d.trial_cnt = '0;
				if (tick)
				begin
					d.st  = IWC_WAIT;
					d.res = word_of(pif.prm[IWC_P_WAK_LO], pif.prm[IWC_P_WAK_HI]);
				end
			end
			IWC_WAIT:
			begin
				if (per_wrap && src[IWC_SRC_TAG])
				begin
					d.st      = IWC_OSC;
					d.dly_cnt = '0;
				end
			end
			IWC_OSC:
			begin
				if (q.dly_cnt >= pif.prm[IWC_P_OSC])
				begin
					d.st      = IWC_DAC;
					d.dly_cnt = '0;
				end
				else if (tick)
				begin
					d.dly_cnt = q.dly_cnt + 8'h01;
				end
			end
			IWC_DAC:
			begin
				if (q.dly_cnt >= pif.prm[IWC_P_DAC])
				begin
					d.st        = IWC_BURST;
					d.swing_cnt = '0;
					d.burst     = 1'b1;
				end
				else if (tick)
				begin
					d.dly_cnt = q.dly_cnt + 8'h01;
				end
			end
			IWC_BURST:
			begin
				if (q.swing_cnt + 8'h01 >= pif.prm[IWC_P_SWING])
				begin
					d.st    = IWC_CMP;
					d.burst = 1'b0;
				end
				else
				begin
					d.swing_cnt = q.swing_cnt + 8'h01;
				end
			end
			IWC_CMP: d.st = IWC_WAIT;
			IWC_LEAVE:
			begin
				d.st       = IWC_READY;
				d.lowp     = 1'b0;
				d.res      = word_of(pif.prm[IWC_P_EXT_LO], pif.prm[IWC_P_EXT_HI]);
				d.resp     = {q.wake_flags, IWC_RES_OK_LEN, IWC_RES_OK};
				d.resp_cnt = 2'h3;
			end
		endcase

		if (waiting && (|hit))
		begin
			d.st         = IWC_LEAVE;
			d.burst      = 1'b0;
			d.wake_flags = {presc, 1'b0, hit};
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			q        <= '0;
			q.st     <= IWC_READY;
			q.wreq   <= 1'b1;
			q.pin_s1 <= 3'h6;
			q.pin_s2 <= 3'h6;
		end
		else
		begin
			q <= d;
		end
	end
endmodule

//--- include/iwc_pkg.sv
package iwc_pkg;

	// ----------------------------------------------------------------
	// command framing
	// ----------------------------------------------------------------
	localparam logic [7:0] IWC_CMD_IDLE     = 8'h07;
	localparam logic [7:0] IWC_LEN_IDLE     = 8'h0e;
	localparam logic [7:0] IWC_RES_OK       = 8'h00;
	localparam logic [7:0] IWC_RES_OK_LEN   = 8'h01;
	localparam logic [7:0] IWC_ERR_LEN      = 8'h82;
	localparam logic [7:0] IWC_ERR_LEN_LEN  = 8'h00;
	localparam int         IWC_NPARAM       = 14;
	localparam int         IWC_IDX_W        = 4;
	localparam logic [3:0] IWC_RX_CODE      = 4'h0;
	localparam logic [3:0] IWC_RX_LEN       = 4'h1;
	localparam logic [3:0] IWC_RX_FIRST     = 4'h2;
	localparam logic [3:0] IWC_RX_LAST      = 4'hf;

	// ----------------------------------------------------------------
	// parameter byte positions
	// ----------------------------------------------------------------
	localparam int IWC_P_SRC     = 0;
	localparam int IWC_P_ENT_LO  = 1;
	localparam int IWC_P_ENT_HI  = 2;
	localparam int IWC_P_WAK_LO  = 3;
	localparam int IWC_P_WAK_HI  = 4;
	localparam int IWC_P_EXT_LO  = 5;
	localparam int IWC_P_EXT_HI  = 6;
	localparam int IWC_P_PERIOD  = 7;
	localparam int IWC_P_OSC     = 8;
	localparam int IWC_P_DAC     = 9;
	localparam int IWC_P_THR_LO  = 10;
	localparam int IWC_P_THR_HI  = 11;
	localparam int IWC_P_SWING   = 12;
	localparam int IWC_P_SLEEP   = 13;

	// ----------------------------------------------------------------
	// source mask fields
	// ----------------------------------------------------------------
	localparam int IWC_SRC_PRESC_HI = 7;
	localparam int IWC_SRC_PRESC_LO = 6;
	localparam int IWC_SRC_SS       = 4;
	localparam int IWC_SRC_IRQ      = 3;
	localparam int IWC_SRC_FIELD    = 2;
	localparam int IWC_SRC_TAG      = 1;
	localparam int IWC_SRC_TMO      = 0;
	localparam int IWC_SRC_N        = 5;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int          IWC_CLK_HZ     = 40_000_000;
	localparam int          IWC_SLOW_HZ    = 32_000;
	localparam int          IWC_SLOW_DIV   = IWC_CLK_HZ / IWC_SLOW_HZ;
	localparam int          IWC_DIV_W      = 14;
	localparam int          IWC_PER_W      = 17;
	localparam logic [16:0] IWC_TREF_TICKS = 17'h00100;
	localparam logic [16:0] IWC_PERIOD_OFS = 17'h00002;
	localparam logic [8:0]  IWC_SLEEP_OFS  = 9'h001;

	// ----------------------------------------------------------------
	// register map, word addresses
	// ----------------------------------------------------------------
	localparam logic [1:0] IWC_REG_CMD  = 2'h0;
	localparam logic [1:0] IWC_REG_RESP = 2'h1;
	localparam logic [1:0] IWC_REG_STAT = 2'h2;
	localparam logic [1:0] IWC_REG_WAKE = 2'h3;

	typedef enum logic [7:0] {
		IWC_READY = 8'h01,
		IWC_ENTER = 8'h02,
		IWC_WAIT  = 8'h04,
		IWC_OSC   = 8'h08,
		IWC_DAC   = 8'h10,
		IWC_BURST = 8'h20,
		IWC_CMP   = 8'h40,
		IWC_LEAVE = 8'h80
	} iwc_state_e;

endpackage

//--- include/iwc_param_if.sv
`timescale 1ns/1ps
interface iwc_param_if;
	import iwc_pkg::*;
	logic                            wr_en;
	logic [IWC_IDX_W-1:0]            wr_idx;
	logic [7:0]                      wr_data;
	logic [IWC_NPARAM-1:0][7:0]      prm;

	modport store (input wr_en, input wr_idx, input wr_data, output prm);
	modport user  (output wr_en, output wr_idx, output wr_data, input prm);
endinterface

//--- logic/iwc_param_store.sv
`timescale 1ns/1ps
module iwc_param_store
	import iwc_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   sys_rst,
	iwc_param_if.store  pif
);
	typedef struct packed {
		logic [IWC_NPARAM-1:0][7:0] prm;
	} iwc_store_s;

	iwc_store_s q, d;

	assign pif.prm = q.prm;

	always_comb
	begin
		d = q;
		if (pif.wr_en)
		begin
			d.prm[pif.wr_idx] = pif.wr_data;
		end
	end

	always_ff @(posedge clk)
	begin
		if (sys_rst)
		begin
			q <= '0;
		end
		else
		begin
			q <= d;
		end
	end
endmodule

//--- test/iwc_properties.sv
`timescale 1ns/1ps
module iwc_properties
#(
	parameter int SLOW_DIV = 1250
)
(
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        avs_read,
	input wire logic        avs_write,
	input wire logic [31:0] avs_readdata,
	input wire logic        avs_waitrequest,
	input wire logic [15:0] resource_word,
	input wire logic        low_power,
	input wire logic        tag_burst
);
	default clocking cb @(posedge clk);
	endclocking

	// --------
	// bus handshake
	// --------
	sequence s_req;
		(avs_read || avs_write) && avs_waitrequest;
	endsequence
	sequence s_ack;
		!avs_waitrequest ##1 avs_waitrequest;
	endsequence

	chk_bus_answer: assert property (disable iff (sys_rst) s_req |=> s_ack)
		else $error("request not answered after one wait cycle");
	chk_bus_quiet: assert property (disable iff (sys_rst)
		!(avs_read || avs_write) |=> avs_waitrequest)
		else $error("wait released without a request");
	chk_read_hold: assert property (disable iff (sys_rst)
		!(avs_read || avs_write) |=> $stable(avs_readdata))
		else $error("read data moved without an access");

	// --------
	// sequencing
	// --------
	chk_reset_out: assert property (sys_rst |=> avs_waitrequest && !low_power &&
		!tag_burst && resource_word == 16'h0000)
		else $error("outputs not cleared by reset");
	chk_res_hold: assert property (disable iff (sys_rst)
		!low_power ##1 !low_power |-> $stable(resource_word))
		else $error("resource word moved while ready");
	chk_burst_start: assert property (disable iff (sys_rst)
		$rose(tag_burst) |-> low_power && $past(low_power))
		else $error("burst outside the wait state");
	chk_burst_end: assert property (disable iff (sys_rst) $fell(tag_burst) |-> low_power)
		else $error("compare step outside the wait state");
	chk_lp_cause: assert property (disable iff (sys_rst) $rose(low_power) |->
		$past(avs_write) || $past(avs_write, 2) || $past(avs_write, 3))
		else $error("low power entered without a command write");
endmodule

bind iwc_idle_wakeup_controller iwc_properties #(.SLOW_DIV(SLOW_DIV)) i_iwc_properties (
	.clk            (clk),
	.sys_rst        (sys_rst),
	.avs_read       (avs_read),
	.avs_write      (avs_write),
	.avs_readdata   (avs_readdata),
	.avs_waitrequest(avs_waitrequest),
	.resource_word  (resource_word),
	.low_power      (low_power),
	.tag_burst      (tag_burst)
);

//--- test/iwc_host_model.sv
`timescale 1ns/1ps
module iwc_host_model
(
	input  wire logic        clk,
	input  wire logic [31:0] avs_readdata,
	input  wire logic        avs_waitrequest,
	output logic      [1:0]  avs_address,
	output logic             avs_read,
	output logic             avs_write,
	output logic      [31:0] avs_writedata
);
	import iwc_pkg::*;

	initial
	begin
		avs_address = 2'h0;
		avs_read = 1'b0;
		avs_write = 1'b0;
		avs_writedata = 32'h0;
	end

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= {24'h000000, d};
		avs_write <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest)
			@(posedge clk);
		avs_write <= 1'b0;
	endtask

	task automatic rd(input logic [1:0] a, output logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_read <= 1'b1;
		@(posedge clk);
		while (avs_waitrequest)
			@(posedge clk);
		d = avs_readdata;
		avs_read <= 1'b0;
	endtask

	// stray byte first, then a full idle command
	task automatic send_idle(input logic [7:0] src);
		logic [7:0] p [17];
		p = '{8'h33, IWC_CMD_IDLE, IWC_LEN_IDLE, src,
			8'h00, 8'h21, 8'h00, 8'h38, 8'h00, 8'h18,
			8'h00, 8'h01, 8'h01, 8'h64, 8'h74, 8'h03,
			8'h01};
		foreach (p[i])
			wr(IWC_REG_CMD, p[i]);
	endtask
endmodule

//--- test/iwc_idle_wakeup_controller_test.sv
`timescale 1ns/1ps
module iwc_idle_wakeup_controller_test;
	import iwc_pkg::*;

	typedef struct {logic [7:0] src; int decoy; int act; logic [7:0] data;} iwc_row_s;

	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic        ss_n = 1'b1;
	logic        irq_in_n = 1'b1;
	logic        field_on = 1'b0;
	logic [7:0]  tag_level = 8'h6c;
	logic [1:0]  avs_address;
	logic        avs_read;
	logic        avs_write;
	logic [31:0] avs_writedata;
	logic [31:0] avs_readdata;
	logic        avs_waitrequest;
	logic [15:0] resource_word;
	logic        low_power;
	logic        tag_burst;
	int          fail_count = 0;
	int          compares = 0;
	// pin codes: 0 none, 1 select, 2 interrupt, 3 field, 4 tag
	iwc_row_s    rows [6] = '{'{8'h08, 1, 2, 8'h08}, '{8'h10, 3, 1, 8'h10},
		'{8'h84, 2, 3, 8'h84}, '{8'h02, 1, 4, 8'h02}, '{8'h41, 3, 0, 8'h41},
		'{8'hc9, 0, 2, 8'hc8}};

	always #12.5 clk = ~clk;

	iwc_idle_wakeup_controller #(.SLOW_DIV(4)) i_iwc_idle_wakeup_controller (
		.clk            (clk),
		.sys_rst        (sys_rst),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.ss_n           (ss_n),
		.irq_in_n       (irq_in_n),
		.field_on       (field_on),
		.tag_level      (tag_level),
		.resource_word  (resource_word),
		.low_power      (low_power),
		.tag_burst      (tag_burst)
	);

	iwc_host_model i_iwc_host_model (
		.clk            (clk),
		.avs_readdata   (avs_readdata),
		.avs_waitrequest(avs_waitrequest),
		.avs_address    (avs_address),
		.avs_read       (avs_read),
		.avs_write      (avs_write),
		.avs_writedata  (avs_writedata)
	);

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic finish_test();
		$display("compares %0d fail_count %0d", compares, fail_count);
		if (fail_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic drive(input int c);
		ss_n <= (c != 1);
		irq_in_n <= (c != 2);
		field_on <= (c == 3);
		tag_level <= (c == 4) ? 8'h80 : 8'h6c;
	endtask

	task automatic wait_lp(input logic v);
		int k;
		k = 0;
		while (low_power !== v && k < 400)
		begin
			@(posedge clk);
			k++;
		end
		check(low_power, v);
	endtask

	initial
	begin
		#1_500_000;
		fail_count++;
		finish_test();
	end

	initial
	begin
		logic [31:0] d;
		int          n;
		int          b;
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		@(posedge clk);
		check(resource_word, 16'h0000);
		i_iwc_host_model.rd(IWC_REG_STAT, d);
		check(d, 32'h001);
		foreach (rows[i])
		begin
			i_iwc_host_model.send_idle(rows[i].src);
			wait_lp(1'b1);
			check(resource_word, 16'h2100);
			n = 0;
			b = 0;
			drive(rows[i].decoy);
			repeat (40)
			begin
				@(posedge clk);
				n++;
			end
			check(low_power, 1'b1);
			check(resource_word, 16'h3800);
			drive(rows[i].act);
			while (low_power === 1'b1 && n < 20000)
			begin
				@(posedge clk);
				n++;
				if (tag_burst === 1'b1)
					b++;
			end
			drive(0);
			check(resource_word, 16'h1800);
			i_iwc_host_model.rd(IWC_REG_RESP, d);
			check(d, 32'h100);
			i_iwc_host_model.rd(IWC_REG_RESP, d);
			check(d, 32'h101);
			i_iwc_host_model.rd(IWC_REG_RESP, d);
			check(d, {23'h0, 1'b1, rows[i].data});
			i_iwc_host_model.rd(IWC_REG_WAKE, d);
			check(d, {24'h0, rows[i].data});
			if (rows[i].act == 0)
				check(n >= 8190 && n <= 8220, 1'b1);
			if (rows[i].act == 4)
				check(b, 3);
		end
		i_iwc_host_model.wr(IWC_REG_CMD, IWC_CMD_IDLE);
		i_iwc_host_model.wr(IWC_REG_CMD, 8'h05);
		i_iwc_host_model.rd(IWC_REG_RESP, d);
		check(d, 32'h182);
		i_iwc_host_model.rd(IWC_REG_RESP, d);
		check(d, 32'h100);
		i_iwc_host_model.rd(IWC_REG_RESP, d);
		check(d[8], 1'b0);
		i_iwc_host_model.rd(IWC_REG_STAT, d);
		check(d, 32'h001);
		finish_test();
	end
endmodule
